/* File: common/rtmc_pkg.sv */
// shared constants of the transmit mode command store
// assumes one 16-bit word per shared-ram address
package rtmc_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int WORD_W = 16;
  localparam int REG_AW = 4;

  // ****************************************************
  // register map, byte offsets on the register port
  // ****************************************************
  localparam logic [3:0] OFS_CFG  = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_CNT  = 4'h8;

  // config register fields and reset value
  localparam int CFG_UNDEF_INV_BIT = 0;
  localparam int CFG_BUSY_BIT      = 1;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // ****************************************************
  // structure layout behind the data pointer
  // ****************************************************
  localparam logic [15:0] OFS_INFO_WORD = 16'h0000;
  localparam logic [15:0] OFS_TAG_WORD  = 16'h0001;
  localparam logic [15:0] OFS_DATA_WORD = 16'h0002;

  // ****************************************************
  // information word fields
  // ****************************************************
  localparam int IW_GAP_BIT  = 13;
  localparam int IW_WCT_BIT  = 12;
  localparam int IW_MSGF_BIT = 10;
  localparam int IW_BUSY_BIT = 9;
  localparam int IW_ILL_BIT  = 8;
  localparam int IW_BUS_BIT  = 5;
  localparam int IW_MC_LSB   = 0;
  localparam int IW_MC_W     = 5;

  // ****************************************************
  // mode codes
  // ****************************************************
  localparam logic [4:0] TRANSMIT_VECTOR_CODE        = 5'h10;
  localparam logic [4:0] UNDEFINED_CODE_17           = 5'h11;
  localparam logic [4:0] TRANSMIT_LAST_COMMAND_CODE  = 5'h12;
  localparam logic [4:0] TRANSMIT_SELFTEST_WORD_CODE = 5'h13;
  localparam logic [4:0] UNDEFINED_CODE_20           = 5'h14;
  localparam logic [4:0] UNDEFINED_CODE_21           = 5'h15;
  localparam int MC_DATA_BIT = 4;

  // ****************************************************
  // sequencer states
  // ****************************************************
  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_DECIDE = 7'h02,
    S_RDWAIT = 7'h04,
    S_RDCAP  = 7'h08,
    S_WAIT   = 7'h10,
    S_WTAG   = 7'h20,
    S_WDATA  = 7'h40
  } rtmc_state_e;

  // address of a word inside the structure
  function automatic logic [15:0] rtmc_word_addr(
    input logic [15:0] ptr,
    input logic [15:0] ofs
  );
    rtmc_word_addr = ptr + ofs;
  endfunction

endpackage

/* File: rtl/rtmc_err_track.sv */
// per-message error collector for gap and word count faults
// assumes fault pulses come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module rtmc_err_track (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic gap_pulse,
  input  wire logic wct_pulse,
  output logic      gap_fault_flag,
  output logic      word_count_fault_flag,
  output logic      message_fault_flag
);

  logic gap_reg;
  logic wct_reg;

  // sticky flags, a set in the clear cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 1'b0;
      wct_reg <= 1'b0;
    end else begin
      gap_reg <= gap_pulse | (gap_reg & ~clear);
      wct_reg <= wct_pulse | (wct_reg & ~clear);
    end
  end

  // a pulse in the closing cycle still counts
  assign gap_fault_flag        = gap_reg | gap_pulse;
  assign word_count_fault_flag = wct_reg | wct_pulse;
  assign message_fault_flag    = gap_fault_flag
                               | word_count_fault_flag;

endmodule
`default_nettype wire

/* File: rtl/rtmc_rst_sync.sv */
// reset release synchroniser
// assumes an asynchronous active-low reset from a pin
`timescale 1ns/1ps
`default_nettype none
module rtmc_rst_sync (
  input  wire logic clk,
  input  wire logic rst_in_n,
  output logic      rst_out_n
);

  logic meta_reg;

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      meta_reg  <= 1'b0;
      rst_out_n <= 1'b0;
    end else begin
      meta_reg  <= 1'b1;
      rst_out_n <= meta_reg;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/rtmc_top.sv */
// transmit mode command store of a remote terminal
// How it works
// - each transmit mode command leaves an info word and a time tag, plus one data word only for codes with data.
// - codes 18 and 19 get their data word from inside, it is sent and then stored at the data slot.
// - with data the pointer holds the info word, the time tag follows and the data word comes after it.
// - info and time tag are written after completion, the data word by the host beforehand except for 18 and 19.
// - codes 0 to 15 store only the info word at the pointer and the time tag after it.
// - undefined codes 17, 20 and 21 answer normally unless illegal or the invalidate bit is set.
// - info bit 13 marks bus activity right after the command where a gap was due.
// - info bit 12 marks unexpected data words arriving with the command.
// - info bit 10 is set whenever bit 12 or bit 13 is set.
// - a busy answer sets info bit 9 and sends no data word, busy being global or per command.
// - info bit 8 copies the illegalization entry of the command.
// - info bit 5 is zero for bus A and one for bus B.
// - info bits 4 to 0 hold the mode code of the command word.
// assumes the protocol engine and the shared ram run on SYS_CLK,
// ram read data arrive one cycle after the read strobe
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rtmc_top
  import rtmc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RESET_N,
  // register port
  input  wire logic [rtmc_pkg::REG_AW-1:0] REG_ADDR,
  input  wire logic [rtmc_pkg::WORD_W-1:0] REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic      [rtmc_pkg::WORD_W-1:0] REG_RDATA,
  // command side from the protocol engine
  input  wire logic                       CMD_VALID,
  input  wire logic [rtmc_pkg::WORD_W-1:0] CMD_WORD,
  input  wire logic                       CMD_BUS_B,
  input  wire logic [rtmc_pkg::WORD_W-1:0] CMD_DATA_PTR,
  input  wire logic                       CMD_PER_BUSY,
  input  wire logic                       CMD_ILLEGAL,
  input  wire logic [rtmc_pkg::WORD_W-1:0] CMD_TIME_TAG,
  input  wire logic [rtmc_pkg::WORD_W-1:0] SELFTEST_WORD,
  input  wire logic                       GAP_SEEN,
  input  wire logic                       EXTRA_WORD,
  input  wire logic                       MSG_DONE,
  // answer to the transmitter
  output logic                            TX_VALID,
  output logic      [rtmc_pkg::WORD_W-1:0] TX_DATA,
  output logic                            RESP_BUSY,
  output logic                            RESP_INVALID,
  // shared ram master
  output logic      [rtmc_pkg::WORD_W-1:0] MEM_ADDR,
  output logic      [rtmc_pkg::WORD_W-1:0] MEM_WDATA,
  output logic                            MEM_WR,
  output logic                            MEM_RD,
  input  wire logic [rtmc_pkg::WORD_W-1:0] MEM_RDATA
);

  import rtmc_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  // reset, state and register port
  logic                rst_n;
  rtmc_state_e         state_reg;
  rtmc_state_e         state_next;
  logic [15:0]         cfg_reg;
  logic [15:0]         info_last_reg;
  logic [CNT_W-1:0]    cnt_reg;
  logic [15:0]         rdata_reg;
  logic [15:0]         rdata_next;

  // fields held for the running message
  logic [15:0]         cmd_reg;
  logic [15:0]         last_cmd_reg;
  logic [15:0]         ptr_reg;
  logic [15:0]         tag_reg;
  logic                bus_b_reg;
  logic                busy_reg;
  logic                ill_reg;

  // registered outputs and their next values
  logic [15:0]         tx_data_reg;
  logic [15:0]         tx_data_next;
  logic                tx_valid_reg;
  logic                tx_valid_next;
  logic [15:0]         mem_addr_reg;
  logic [15:0]         mem_addr_next;
  logic [15:0]         mem_wdata_reg;
  logic [15:0]         mem_wdata_next;
  logic                mem_wr_reg;
  logic                mem_wr_next;
  logic                mem_rd_reg;
  logic                mem_rd_next;

  // fault flags of the running message
  logic                gap_f;
  logic                wct_f;
  logic                msg_f;

  // ****************************************************
  // reset release
  // ****************************************************
  rtmc_rst_sync u_rst (
    .clk       (SYS_CLK),
    .rst_in_n  (RESET_N),
    .rst_out_n (rst_n)
  );

  // ****************************************************
  // register port decode
  // ****************************************************
  wire hit_cfg  = (REG_ADDR == OFS_CFG);
  wire hit_stat = (REG_ADDR == OFS_STAT);
  wire hit_cnt  = (REG_ADDR == OFS_CNT);
  wire cfg_wr   = REG_WR & hit_cfg;
  wire inv_en   = cfg_reg[CFG_UNDEF_INV_BIT];
  wire glb_busy = cfg_reg[CFG_BUSY_BIT];

  // read mux, unmapped reads give zero
  always_comb begin
    rdata_next = 16'h0000;
    if (hit_cfg) begin
      rdata_next = cfg_reg;
    end else if (hit_stat) begin
      rdata_next = info_last_reg;
    end else if (hit_cnt) begin
      rdata_next = 16'(cnt_reg);
    end
  end

  // config write and read data flop
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg   <= CFG_RST;
      rdata_reg <= 16'h0000;
    end else begin
      if (cfg_wr) begin
        cfg_reg <= REG_WDATA;
      end
      rdata_reg <= REG_RD ? rdata_next : 16'h0000;
    end
  end

  // ****************************************************
  // command classification
  // ****************************************************
  // a command is taken only while idle, others are ignored
  wire       take      = CMD_VALID & (state_reg == S_IDLE);
  wire [4:0] mc        = cmd_reg[4:0];
  wire       with_data = mc[MC_DATA_BIT];
  wire       undef_mc  = (mc == UNDEFINED_CODE_17)
                       | (mc == UNDEFINED_CODE_20)
                       | (mc == UNDEFINED_CODE_21);
  wire       is_last   = (mc == TRANSMIT_LAST_COMMAND_CODE);
  wire       is_self   = (mc == TRANSMIT_SELFTEST_WORD_CODE);
  wire       own_word  = is_last | is_self;
  // undefined codes still answer unless invalidated
  wire       invalid   = ill_reg | (undef_mc & inv_en);
  // busy suppresses the data word
  wire       send_data = with_data & ~busy_reg & ~invalid;
  wire [15:0] own_val  = is_last ? last_cmd_reg : SELFTEST_WORD;

  // info word, unused bits held at zero
  wire [15:0] info_word = {
    2'b00,
    gap_f,
    wct_f,
    1'b0,
    msg_f,
    busy_reg,
    ill_reg,
    2'b00,
    bus_b_reg,
    mc
  };

  // ****************************************************
  // per-message fault flags
  // ****************************************************
  rtmc_err_track u_err (
    .clk                   (SYS_CLK),
    .rst_n                 (rst_n),
    .clear                 (take),
    .gap_pulse             (GAP_SEEN),
    .wct_pulse             (EXTRA_WORD),
    .gap_fault_flag        (gap_f),
    .word_count_fault_flag (wct_f),
    .message_fault_flag    (msg_f)
  );

  // ****************************************************
  // command capture
  // ****************************************************
  // latch the command fields when taken
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg      <= 16'h0000;
      last_cmd_reg <= 16'h0000;
      ptr_reg      <= 16'h0000;
      tag_reg      <= 16'h0000;
      bus_b_reg    <= 1'b0;
      busy_reg     <= 1'b0;
      ill_reg      <= 1'b0;
    end else if (take) begin
      cmd_reg      <= CMD_WORD;
      last_cmd_reg <= cmd_reg;
      ptr_reg      <= CMD_DATA_PTR;
      tag_reg      <= CMD_TIME_TAG;
      bus_b_reg    <= CMD_BUS_B;
      busy_reg     <= glb_busy | CMD_PER_BUSY;
      ill_reg      <= CMD_ILLEGAL;
    end
  end

  // ****************************************************
  // sequencer
  // ****************************************************
  always_comb begin
    state_next     = state_reg;
    tx_data_next   = tx_data_reg;
    tx_valid_next  = 1'b0;
    mem_addr_next  = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_wr_next    = 1'b0;
    mem_rd_next    = 1'b0;
    unique case (state_reg)
      // wait for a taken command
      S_IDLE: begin
        if (CMD_VALID) begin
          state_next = S_DECIDE;
        end
      end

      // own word, table fetch or no data word at all
      S_DECIDE: begin
        state_next = S_WAIT;
        if (send_data && own_word) begin
          tx_data_next  = own_val;
          tx_valid_next = 1'b1;
        end else if (send_data) begin
          // host preloaded word at the data slot
          mem_rd_next   = 1'b1;
          mem_addr_next = rtmc_word_addr(ptr_reg, OFS_DATA_WORD);
          state_next    = S_RDWAIT;
        end
      end

      // ram read in flight
      S_RDWAIT: begin
        state_next = S_RDCAP;
      end

      // table word handed to the transmitter
      S_RDCAP: begin
        tx_data_next  = MEM_RDATA;
        tx_valid_next = 1'b1;
        state_next    = S_WAIT;
      end

      // hold until the message completes
      S_WAIT: begin
        if (MSG_DONE) begin
          // info word only after completion
          mem_wr_next    = 1'b1;
          mem_addr_next  = rtmc_word_addr(ptr_reg, OFS_INFO_WORD);
          mem_wdata_next = info_word;
          state_next     = S_WTAG;
        end
      end

      // time tag at the next address
      S_WTAG: begin
        mem_wr_next    = 1'b1;
        mem_addr_next  = rtmc_word_addr(ptr_reg, OFS_TAG_WORD);
        mem_wdata_next = tag_reg;
        state_next     = (send_data && own_word) ? S_WDATA : S_IDLE;
      end

      S_WDATA: begin
        // internal word copied after it was sent
        mem_wr_next    = 1'b1;
        mem_addr_next  = rtmc_word_addr(ptr_reg, OFS_DATA_WORD);
        mem_wdata_next = tx_data_reg;
        state_next     = S_IDLE;
      end

      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // ****************************************************
  // state and output flops
  // ****************************************************
  // whole sequencer advances on every rising edge
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= S_IDLE;
      tx_data_reg   <= 16'h0000;
      tx_valid_reg  <= 1'b0;
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= 16'h0000;
      mem_wr_reg    <= 1'b0;
      mem_rd_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      tx_data_reg   <= tx_data_next;
      tx_valid_reg  <= tx_valid_next;
      mem_addr_reg  <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_wr_reg    <= mem_wr_next;
      mem_rd_reg    <= mem_rd_next;
    end
  end

  // ****************************************************
  // status: last info word and stored count
  // ****************************************************
  // info word leaves in this cycle
  wire info_wr = (state_reg == S_WAIT) & MSG_DONE;

  // latest info word and count of stored structures
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      info_last_reg <= 16'h0000;
      cnt_reg       <= '0;
    end else if (info_wr) begin
      info_last_reg <= info_word;
      cnt_reg       <= cnt_reg + 1'b1;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // all registered except the invalid level
  assign REG_RDATA    = rdata_reg;
  assign TX_VALID     = tx_valid_reg;
  assign TX_DATA      = tx_data_reg;
  assign RESP_BUSY    = busy_reg;
  assign RESP_INVALID = invalid;
  assign MEM_ADDR     = mem_addr_reg;
  assign MEM_WDATA    = mem_wdata_reg;
  assign MEM_WR       = mem_wr_reg;
  assign MEM_RD       = mem_rd_reg;

endmodule
`default_nettype wire

/* File: verif/rtmc_assertions.sv */
// checker of the transmit mode command store
// assumes it is bound to rtmc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rtmc_assertions
  import rtmc_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              RESET_N,
  input wire logic [REG_AW-1:0] REG_ADDR,
  input wire logic [WORD_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              CMD_VALID,
  input wire logic [WORD_W-1:0] CMD_WORD,
  input wire logic              CMD_BUS_B,
  input wire logic [WORD_W-1:0] CMD_DATA_PTR,
  input wire logic              CMD_PER_BUSY,
  input wire logic              CMD_ILLEGAL,
  input wire logic [WORD_W-1:0] CMD_TIME_TAG,
  input wire logic              GAP_SEEN,
  input wire logic              EXTRA_WORD,
  input wire logic              MSG_DONE,
  input wire logic              TX_VALID,
  input wire logic [WORD_W-1:0] TX_DATA,
  input wire logic              RESP_BUSY,
  input wire logic              RESP_INVALID,
  input wire logic [WORD_W-1:0] MEM_ADDR,
  input wire logic [WORD_W-1:0] MEM_WDATA,
  input wire logic              MEM_WR,
  input wire logic              MEM_RD,
  input wire logic [WORD_W-1:0] MEM_RDATA
);
  // ****************************************************
  // command fields held for the running message
  // ****************************************************
  logic [15:0] ptr_q, tag_q, tx_q;
  logic [4:0]  mc_q;
  logic        bus_q, ill_q, bsy_q, gbsy_q, gap_q, wct_q;
  wire info_wr = MEM_WR && MEM_ADDR == ptr_q;
  wire tag_wr  = MEM_WR && MEM_ADDR == ptr_q + 16'h0001;
  wire own_mc  = mc_q == TRANSMIT_LAST_COMMAND_CODE ||
                 mc_q == TRANSMIT_SELFTEST_WORD_CODE;
  wire own_in  = CMD_WORD[4:0] == TRANSMIT_LAST_COMMAND_CODE ||
                 CMD_WORD[4:0] == TRANSMIT_SELFTEST_WORD_CODE;
  // latch on every CMD_VALID, even one the design ignores, collect faults until the next command
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {ptr_q, tag_q, tx_q, mc_q} <= '0;
      {bus_q, ill_q, bsy_q, gbsy_q, gap_q, wct_q} <= '0;
    end else begin
      if (REG_WR && REG_ADDR == OFS_CFG) gbsy_q <= REG_WDATA[CFG_BUSY_BIT];
      if (TX_VALID) tx_q <= TX_DATA;
      if (CMD_VALID) begin
        {ptr_q, tag_q, mc_q} <= {CMD_DATA_PTR, CMD_TIME_TAG, CMD_WORD[4:0]};
        {bus_q, ill_q, bsy_q} <= {CMD_BUS_B, CMD_ILLEGAL,
                                  CMD_PER_BUSY | gbsy_q};
        {gap_q, wct_q} <= {GAP_SEEN, EXTRA_WORD};
      end else begin
        if (GAP_SEEN) gap_q <= 1'b1;
        if (EXTRA_WORD) wct_q <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // ****************************************************
  // properties
  // ****************************************************
  property p_info_after_done;
    MSG_DONE |-> ##[1:2] info_wr;
  endproperty
  a_info_after_done: assert property (p_info_after_done)
    else $error("info word not written after completion");
  property p_tag;
    info_wr |=> tag_wr && MEM_WDATA == tag_q;
  endproperty
  a_tag: assert property (p_tag)
    else $error("time tag not at next address");
  property p_fields;
    info_wr |-> MEM_WDATA[4:0] == mc_q && MEM_WDATA[5] == bus_q;
  endproperty
  a_fields: assert property (p_fields)
    else $error("mode code or bus bit wrong");
  property p_zero;
    info_wr |-> MEM_WDATA[15:14] == 2'h0 && !MEM_WDATA[11] &&
      MEM_WDATA[7:6] == 2'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("unused info bits not zero");
  property p_faults;
    info_wr |-> MEM_WDATA[13] == gap_q && MEM_WDATA[12] == wct_q;
  endproperty
  a_faults: assert property (p_faults)
    else $error("fault bits wrong");
  property p_message_fault_flag;
    info_wr |-> MEM_WDATA[10] == (gap_q | wct_q);
  endproperty
  a_message_fault_flag: assert property (p_message_fault_flag)
    else $error("message fault bit wrong");
  property p_busy_ill;
    info_wr |-> MEM_WDATA[9] == bsy_q && MEM_WDATA[8] == ill_q;
  endproperty
  a_busy_ill: assert property (p_busy_ill)
    else $error("busy or illegal bit wrong");
  property p_busy_tx;
    CMD_VALID && (CMD_PER_BUSY || gbsy_q) |=> (!TX_VALID) [*6];
  endproperty
  a_busy_tx: assert property (p_busy_tx)
    else $error("data word sent while busy");
  property p_own_data;
    tag_wr && own_mc && !bsy_q && !ill_q |=>
      MEM_WR && MEM_ADDR == ptr_q + 16'h0002 && MEM_WDATA == tx_q;
  endproperty
  a_own_data: assert property (p_own_data)
    else $error("sent word not stored");
  property p_nodata;
    tag_wr && !own_mc |=> !MEM_WR;
  endproperty
  a_nodata: assert property (p_nodata)
    else $error("extra structure word written");
  property p_fetch;
    MEM_RD && !RESP_BUSY && !RESP_INVALID |-> MEM_ADDR == ptr_q + 16'h0002
      ##2 TX_VALID && TX_DATA == $past(MEM_RDATA);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("table word not sent");
  property p_own_noread;
    CMD_VALID && own_in |=> (!MEM_RD) [*6];
  endproperty
  a_own_noread: assert property (p_own_noread)
    else $error("table read for own data word");
endmodule
bind rtmc_top rtmc_assertions u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .CMD_VALID(CMD_VALID),
  .CMD_WORD(CMD_WORD), .CMD_BUS_B(CMD_BUS_B), .CMD_DATA_PTR(CMD_DATA_PTR),
  .CMD_PER_BUSY(CMD_PER_BUSY), .CMD_ILLEGAL(CMD_ILLEGAL),
  .CMD_TIME_TAG(CMD_TIME_TAG), .GAP_SEEN(GAP_SEEN),
  .EXTRA_WORD(EXTRA_WORD), .MSG_DONE(MSG_DONE), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .RESP_BUSY(RESP_BUSY), .RESP_INVALID(RESP_INVALID),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR),
  .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA));
`default_nettype wire

/* File: verif/rtmc_ram_model.sv */
// shared ram with words the host loads beforehand
// assumes one word per address, read data one cycle late
`timescale 1ns/1ps
`default_nettype none
module rtmc_ram_model (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata
);
  logic [15:0] mem [0:65535]; // host loads data words here
  // write port; read data stand one cycle, then change
  always @(posedge clk) begin
    if (wr) mem[addr] <= wdata;
    if (rd) rdata <= mem[addr];
    else rdata <= ~rdata;
  end
  initial rdata = 16'h0000;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// bench of the transmit mode command store
// assumes rtmc_ram_model in place of the shared ram
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtmc_pkg::*;
  logic        SYS_CLK = 1'b0, RESET_N = 1'b0;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = '0, CMD_WORD = '0, CMD_DATA_PTR = '0;
  logic [15:0] CMD_TIME_TAG = '0, SELFTEST_WORD = 16'hC35A;
  logic [15:0] REG_RDATA, TX_DATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [15:0] last_cw = '0, txd = '0;
  logic        REG_WR = 0, REG_RD = 0, CMD_VALID = 0, CMD_BUS_B = 0;
  logic        CMD_PER_BUSY = 0, CMD_ILLEGAL = 0, GAP_SEEN = 0;
  logic        EXTRA_WORD = 0, MSG_DONE = 0, TX_VALID, RESP_BUSY;
  logic        RESP_INVALID, MEM_WR, MEM_RD;
  int          fails = 0, checked = 0, txn = 0, nmsg = 0;
  always #20 SYS_CLK = ~SYS_CLK;
  rtmc_top dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CMD_VALID(CMD_VALID), .CMD_WORD(CMD_WORD),
    .CMD_BUS_B(CMD_BUS_B), .CMD_DATA_PTR(CMD_DATA_PTR),
    .CMD_PER_BUSY(CMD_PER_BUSY), .CMD_ILLEGAL(CMD_ILLEGAL),
    .CMD_TIME_TAG(CMD_TIME_TAG), .SELFTEST_WORD(SELFTEST_WORD),
    .GAP_SEEN(GAP_SEEN), .EXTRA_WORD(EXTRA_WORD), .MSG_DONE(MSG_DONE),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .RESP_BUSY(RESP_BUSY),
    .RESP_INVALID(RESP_INVALID), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
    .MEM_RDATA(MEM_RDATA));
  rtmc_ram_model ram (.clk(SYS_CLK), .addr(MEM_ADDR), .wdata(MEM_WDATA),
    .wr(MEM_WR), .rd(MEM_RD), .rdata(MEM_RDATA));
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge SYS_CLK);
    {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask
  // one transmit mode command from acceptance to stored structure
  task automatic msg(input logic [4:0] mc, input logic [15:0] p,
    input logic bus, pb, ill, gb, inv, input logic [1:0] f);
    logic [15:0] cw, info, dat, etx;
    logic        tx, undef;
    cw = {p[10:0] ^ 11'h2A5, mc};
    dat = 16'h6000 | p;
    ram.mem[p + 16'h0002] = dat;
    undef = mc == UNDEFINED_CODE_17 || mc == UNDEFINED_CODE_20 ||
            mc == UNDEFINED_CODE_21;
    tx = mc[MC_DATA_BIT] & !(pb | gb) & !ill & !(inv & undef);
    etx = mc == TRANSMIT_LAST_COMMAND_CODE ? last_cw :
          mc == TRANSMIT_SELFTEST_WORD_CODE ? SELFTEST_WORD : dat;
    info = {2'h0, f, 1'b0, |f, pb | gb, ill, 2'h0, bus, mc};
    wr(OFS_CFG, {14'h0, gb, inv});
    txn = 0;
    @(posedge SYS_CLK);
    {CMD_VALID, CMD_WORD, CMD_DATA_PTR, CMD_BUS_B} <= {1'b1, cw, p, bus};
    {CMD_PER_BUSY, CMD_ILLEGAL, CMD_TIME_TAG} <= {pb, ill, p ^ 16'h0F0F};
    @(posedge SYS_CLK);
    {CMD_VALID, GAP_SEEN, EXTRA_WORD} <= {1'b0, f};
    @(posedge SYS_CLK);
    {GAP_SEEN, EXTRA_WORD} <= 2'b00;
    repeat (5) @(posedge SYS_CLK);
    MSG_DONE <= 1'b1;
    @(posedge SYS_CLK);
    MSG_DONE <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    #1 chk(16'(txn), 16'(tx));
    chk({14'h0, RESP_BUSY, RESP_INVALID},
        {14'h0, pb | gb, ill | (inv & undef)});
    if (tx) chk(txd, etx);
    chk(ram.mem[p], info);
    chk(ram.mem[p + 16'h0001], p ^ 16'h0F0F);
    chk(ram.mem[p + 16'h0002], tx ? etx : dat);
    rd(OFS_STAT, info);
    nmsg++;
    last_cw = cw;
    $display("test done: mode code %h", mc);
  endtask
  // transmitted words seen on the answer side
  always @(posedge SYS_CLK) begin
    if (TX_VALID === 1'b1) begin
      txn++;
      txd = TX_DATA;
    end
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    rd(OFS_CFG, CFG_RST);
    rd(4'hC, 16'h0000);
    wr(OFS_STAT, 16'hFFFF);
    rd(OFS_STAT, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      msg(5'(i), 16'h0100 + 16'(i * 4), i[0], 0, 0, 0, 0, 2'b00);
    end
    msg(TRANSMIT_VECTOR_CODE, 16'h0200, 0, 1, 0, 0, 0, 2'b00);
    msg(TRANSMIT_SELFTEST_WORD_CODE, 16'h0210, 1, 0, 0, 1, 0, 2'b00);
    msg(TRANSMIT_VECTOR_CODE, 16'h0220, 0, 0, 1, 0, 0, 2'b00);
    msg(UNDEFINED_CODE_17, 16'h0230, 1, 0, 0, 0, 1, 2'b00);
    msg(5'h05, 16'h0240, 0, 0, 0, 0, 0, 2'b10);
    msg(TRANSMIT_LAST_COMMAND_CODE, 16'h0250, 1, 0, 0, 0, 0, 2'b01);
    rd(OFS_CNT, 16'(nmsg));
    end_sim;
  end
  // hang guard
  initial begin
    #2000000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
